//--- verilog/ebc_defines.svh
`ifndef EBC_DEFINES_SVH
`define EBC_DEFINES_SVH
`define EBC_CYC_W       6
`define EBC_CYC_ZERO    6'h00
`define EBC_CYC_ONE     6'h01
`define EBC_CYC_MAX     6'h3f
`define EBC_AB_BASE     6'h01
`define EBC_E_BASE      6'h01
`define EBC_RST_WIN     3'h0
`define EBC_RST_ADDR    24'h000000
`define EBC_RST_DATA    16'h0000
`define EBC_RST_CFG     16'h0000
`endif

//--- verilog/ebc_pkg.sv
package ebc_pkg;
  typedef struct packed {
    logic       setup_ext;
    logic [1:0] window_ext;
    logic [1:0] cmd_delay;
    logic       wdata_setup;
    logic [4:0] access;
    logic [1:0] hold;
    logic       ready_en;
    logic       ready_pol;
    logic       ready_async;
  } ebc_cfg_t;
  typedef enum logic [9:0] {
    ST_IDLE     = 10'h001,
    ST_AB       = 10'h002,
    ST_C        = 10'h004,
    ST_D        = 10'h008,
    ST_E        = 10'h010,
    ST_WAIT     = 10'h020,
    ST_F        = 10'h040,
    ST_REL      = 10'h080,
    ST_RELEASED = 10'h100,
    ST_REGAIN   = 10'h200
  } ebc_state_t;
endpackage

//--- verilog/ebc_timer_if.sv
`include "ebc_defines.svh"
interface ebc_timer_if;
  logic                 load;
  logic [`EBC_CYC_W-1:0] value;
  logic                 last;
  modport ctl (output load, output value, input last);
  modport cnt (input load, input value, output last);
endinterface

//--- verilog/ebc_sync3.sv
module ebc_sync3 #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic sig_in,
  output logic      sig_out
);
  logic [2:0] pipe_reg;
  logic [2:0] pipe_next;
  logic       level_reg;
  logic       level_next;

  // Stage 0 feeds only stage 1; a change counts once 1 and 2 agree
  always_comb begin
    pipe_next  = {pipe_reg[1:0], sig_in};
    level_next = (pipe_reg[2] == pipe_reg[1]) ? pipe_reg[2] : level_reg;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pipe_reg  <= {3{INIT}};
      level_reg <= INIT;
    end else begin
      pipe_reg  <= pipe_next;
      level_reg <= level_next;
    end
  end

  assign sig_out = level_reg;
endmodule // ebc_sync3

//--- verilog/ebc_phase_timer.sv
`include "ebc_defines.svh"
module ebc_phase_timer (
  input wire logic clock_in,
  input wire logic rst_n_in,
  ebc_timer_if.cnt tmr
);
  logic [`EBC_CYC_W-1:0] cnt_reg;
  logic [`EBC_CYC_W-1:0] cnt_next;

  always_comb begin
    if (tmr.load) begin
      cnt_next = tmr.value;
    end else if (cnt_reg != `EBC_CYC_ZERO) begin
      cnt_next = cnt_reg - `EBC_CYC_ONE;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= `EBC_CYC_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign tmr.last = (cnt_reg == `EBC_CYC_ZERO);
endmodule // ebc_phase_timer

//--- verilog/ebc_bus_cycle.sv
`include "ebc_defines.svh"
// Operation
// - Each external cycle runs address setup, command delay, data setup, access, hold.
// - Address setup lasts 1-2 periods, plus 0-3 on window change.
// - Command delay 0-3 periods; write data setup 0-1 period.
// - Access 1-32 periods; hold 0-3 periods, from the timing config.
// - If enabled, the external ready input stretches the access phase.
// - Software picks the active level of the ready input.
// - Synchronous ready is sampled directly; partner keeps it clock aligned.
// - Asynchronous ready passes a synchroniser; always at least one waitstate.
// - Ready sampled inactive inserts a waitstate and samples again.
// - Ready active ends the access phase, checked only after mandatory waitstates.
// - Read data captured on the edge raising read strobe.
// - Hold request waits until the running cycle has finished.
// - Release drives controls inactive, then floats them; latch enable low.
// - Regain drives controls inactive before the next own cycle.
// - Regain starts only when the hold request goes away.
// - External master may end hold without a regain request.
module ebc_bus_cycle #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16,
  parameter int WIN_W  = 3
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  ebc_pkg::ebc_cfg_t     chip_select_timing_config_in,
  input  wire logic             req_valid_in,
  input  wire logic             req_write_in,
  input  wire logic             req_upper_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [WIN_W-1:0] req_window_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  output logic                  req_ready_out,
  output logic                  done_out,
  output logic [DATA_W-1:0]     rdata_out,
  output logic [ADDR_W-1:0]     addr_out,
  output logic                  upper_byte_enable_n_out,
  output logic                  ale_out,
  output logic                  cs_n_out,
  output logic                  rd_n_out,
  output logic                  wr_n_out,
  output logic                  ctrl_oe_out,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]     data_out,
  output logic                  data_oe_out,
  input  wire logic             ready_in,
  input  wire logic             hold_n_in,
  output logic                  bus_grant_acknowledge_out,
  output logic                  bus_regain_request_out
);
  localparam int CW = `EBC_CYC_W;

  ebc_pkg::ebc_state_t   state_reg;
  ebc_pkg::ebc_state_t   state_next;
  ebc_pkg::ebc_cfg_t     cfg_reg;
  ebc_pkg::ebc_cfg_t     cfg_next;
  logic [ADDR_W-1:0]     addr_reg;
  logic [ADDR_W-1:0]     addr_next;
  logic [DATA_W-1:0]     wdata_reg;
  logic [DATA_W-1:0]     wdata_next;
  logic [DATA_W-1:0]     rdata_reg;
  logic [DATA_W-1:0]     rdata_next;
  logic [WIN_W-1:0]      win_reg;
  logic [WIN_W-1:0]      win_next;
  logic                  win_chg_reg;
  logic                  win_chg_next;
  logic                  write_reg;
  logic                  write_next;
  logic                  upper_reg;
  logic                  upper_next;
  logic                  done_reg;
  logic                  done_next;
  logic                  ready_sync;
  logic                  hold_n_sync;
  logic                  hold_act;
  logic                  ready_ok;
  logic                  accept;
  logic                  end_access;
  logic                  in_cycle;
  logic [CW-1:0]         cyc_reg;
  logic [CW-1:0]         cyc_next;

  ebc_timer_if tmr ();

  ebc_phase_timer u_timer (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .tmr      (tmr.cnt)
  );

  ebc_sync3 #(.INIT(1'b0)) u_ready_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .sig_in   (ready_in),
    .sig_out  (ready_sync)
  );

  ebc_sync3 #(.INIT(1'b1)) u_hold_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .sig_in   (hold_n_in),
    .sig_out  (hold_n_sync)
  );

  // Phase length in periods, zero meaning the phase is skipped
  function automatic logic [CW-1:0] phase_len(
    input ebc_pkg::ebc_state_t st,
    input ebc_pkg::ebc_cfg_t   cfg,
    input logic                chg
  );
    logic [CW-1:0] len;
    len = `EBC_CYC_ZERO;
    unique case (st)
      ebc_pkg::ST_AB: len = `EBC_AB_BASE + CW'(cfg.setup_ext)
                            + (chg ? CW'(cfg.window_ext) : `EBC_CYC_ZERO);
      ebc_pkg::ST_C:  len = CW'(cfg.cmd_delay);
      ebc_pkg::ST_D:  len = CW'(cfg.wdata_setup);
      ebc_pkg::ST_E:  len = `EBC_E_BASE + CW'(cfg.access);
      ebc_pkg::ST_F:  len = CW'(cfg.hold);
      default:        len = `EBC_CYC_ZERO;
    endcase
    return len;
  endfunction

  // First phase after st that has a nonzero length
  function automatic ebc_pkg::ebc_state_t next_phase(
    input ebc_pkg::ebc_state_t st,
    input ebc_pkg::ebc_cfg_t   cfg
  );
    ebc_pkg::ebc_state_t nx;
    nx = ebc_pkg::ST_IDLE;
    if (st == ebc_pkg::ST_AB && cfg.cmd_delay != 2'h0) begin
      nx = ebc_pkg::ST_C;
    end else if (st inside {ebc_pkg::ST_AB, ebc_pkg::ST_C}
                 && cfg.wdata_setup) begin
      nx = ebc_pkg::ST_D;
    end else if (st inside {ebc_pkg::ST_AB, ebc_pkg::ST_C,
                            ebc_pkg::ST_D}) begin
      nx = ebc_pkg::ST_E;
    end else if (cfg.hold != 2'h0) begin
      nx = ebc_pkg::ST_F;
    end
    return nx;
  endfunction

  assign hold_act = !hold_n_sync;
  // Sync mode skips the synchroniser for the shortest cycle
  assign ready_ok = cfg_reg.ready_async
                    ? (ready_sync == cfg_reg.ready_pol)
                    : (ready_in == cfg_reg.ready_pol);
  // Hold is only honoured from idle, so a running cycle completes
  assign accept = (state_reg == ebc_pkg::ST_IDLE) && !hold_act
                  && req_valid_in;
  assign end_access =
    (state_reg == ebc_pkg::ST_E && tmr.last
     && (!cfg_reg.ready_en
         || (!cfg_reg.ready_async && ready_ok)))
    || (state_reg == ebc_pkg::ST_WAIT && ready_ok);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ebc_pkg::ST_IDLE: begin
        if (hold_act) begin
          state_next = ebc_pkg::ST_REL;
        end else if (req_valid_in) begin
          state_next = ebc_pkg::ST_AB;
        end
      end
      ebc_pkg::ST_AB, ebc_pkg::ST_C, ebc_pkg::ST_D: begin
        if (tmr.last) begin
          state_next = next_phase(state_reg, cfg_reg);
        end
      end
      ebc_pkg::ST_E: begin
        if (end_access) begin
          state_next = next_phase(state_reg, cfg_reg);
        end else if (tmr.last) begin
          state_next = ebc_pkg::ST_WAIT;
        end
      end
      ebc_pkg::ST_WAIT: begin
        if (end_access) begin
          state_next = next_phase(state_reg, cfg_reg);
        end
      end
      ebc_pkg::ST_F: begin
        if (tmr.last) begin
          state_next = ebc_pkg::ST_IDLE;
        end
      end
      ebc_pkg::ST_REL: begin
        state_next = ebc_pkg::ST_RELEASED;
      end
      ebc_pkg::ST_RELEASED: begin
        if (!hold_act) begin
          state_next = ebc_pkg::ST_REGAIN;
        end
      end
      ebc_pkg::ST_REGAIN: begin
        state_next = ebc_pkg::ST_IDLE;
      end
      default: state_next = ebc_pkg::ST_IDLE;
    endcase
  end

  // Config is frozen per cycle so a mid-cycle change cannot tear it
  always_comb begin
    cfg_next     = cfg_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    win_next     = win_reg;
    win_chg_next = win_chg_reg;
    write_next   = write_reg;
    upper_next   = upper_reg;
    rdata_next   = rdata_reg;
    done_next    = end_access;
    if (accept) begin
      cfg_next     = chip_select_timing_config_in;
      addr_next    = req_addr_in;
      wdata_next   = req_wdata_in;
      win_next     = req_window_in;
      win_chg_next = (req_window_in != win_reg);
      write_next   = req_write_in;
      upper_next   = req_upper_in;
    end
    if (end_access && !write_reg) begin
      rdata_next = data_in;
    end
  end

  assign tmr.load  = (state_next != state_reg);
  assign tmr.value = phase_len(state_next, cfg_next, win_chg_next)
                     - `EBC_CYC_ONE;

  always_comb begin
    if (state_next != state_reg) begin
      cyc_next = `EBC_CYC_ZERO;
    end else if (cyc_reg != `EBC_CYC_MAX) begin
      cyc_next = cyc_reg + `EBC_CYC_ONE;
    end else begin
      cyc_next = cyc_reg;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg   <= ebc_pkg::ST_IDLE;
      cfg_reg     <= `EBC_RST_CFG;
      addr_reg    <= `EBC_RST_ADDR;
      wdata_reg   <= `EBC_RST_DATA;
      rdata_reg   <= `EBC_RST_DATA;
      win_reg     <= `EBC_RST_WIN;
      win_chg_reg <= 1'b0;
      write_reg   <= 1'b0;
      upper_reg   <= 1'b0;
      done_reg    <= 1'b0;
      cyc_reg     <= `EBC_CYC_ZERO;
    end else begin
      state_reg   <= state_next;
      cfg_reg     <= cfg_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      rdata_reg   <= rdata_next;
      win_reg     <= win_next;
      win_chg_reg <= win_chg_next;
      write_reg   <= write_next;
      upper_reg   <= upper_next;
      done_reg    <= done_next;
      cyc_reg     <= cyc_next;
    end
  end

  assign in_cycle = state_reg inside {ebc_pkg::ST_AB, ebc_pkg::ST_C,
                    ebc_pkg::ST_D, ebc_pkg::ST_E, ebc_pkg::ST_WAIT,
                    ebc_pkg::ST_F};
  assign req_ready_out = (state_reg == ebc_pkg::ST_IDLE) && !hold_act;
  assign done_out  = done_reg;
  assign rdata_out = rdata_reg;
  assign addr_out  = addr_reg;
  assign data_out  = wdata_reg;
  // Latch enable stays driven, so it is low while released
  assign ale_out   = (state_reg == ebc_pkg::ST_AB);
  assign cs_n_out  = !in_cycle;
  assign rd_n_out  = !(!write_reg && state_reg inside
                       {ebc_pkg::ST_E, ebc_pkg::ST_WAIT});
  assign wr_n_out  = !(write_reg && state_reg inside
                       {ebc_pkg::ST_E, ebc_pkg::ST_WAIT});
  assign upper_byte_enable_n_out = !(upper_reg && in_cycle);
  assign ctrl_oe_out = (state_reg != ebc_pkg::ST_RELEASED);
  assign data_oe_out = write_reg && state_reg inside {ebc_pkg::ST_D,
                       ebc_pkg::ST_E, ebc_pkg::ST_WAIT, ebc_pkg::ST_F};
  assign bus_grant_acknowledge_out =
    (state_reg == ebc_pkg::ST_RELEASED);
  assign bus_regain_request_out =
    (state_reg == ebc_pkg::ST_RELEASED) && req_valid_in;

  // Checks
  state_onehot_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) $onehot(state_reg))
    else $error("state not one-hot");
  ab_length_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (state_reg == ebc_pkg::ST_AB && state_next != ebc_pkg::ST_AB)
    |-> cyc_reg == CW'(cfg_reg.setup_ext)
        + (win_chg_reg ? CW'(cfg_reg.window_ext) : `EBC_CYC_ZERO))
    else $error("address setup length wrong");
  cmd_length_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    $fell(state_reg == ebc_pkg::ST_C)
    |-> $past(cyc_reg) == CW'(cfg_reg.cmd_delay) - `EBC_CYC_ONE)
    else $error("command delay length wrong");
  access_length_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (state_reg == ebc_pkg::ST_E && state_next != ebc_pkg::ST_E)
    |-> cyc_reg == CW'(cfg_reg.access))
    else $error("access phase length wrong");
  async_wait_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (state_reg == ebc_pkg::ST_E && tmr.last && cfg_reg.ready_en
     && cfg_reg.ready_async) |=> state_reg == ebc_pkg::ST_WAIT)
    else $error("async ready without waitstate");
  ready_wait_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (state_reg == ebc_pkg::ST_WAIT && !ready_ok)
    |=> state_reg == ebc_pkg::ST_WAIT && !rd_n_out == !write_reg)
    else $error("inactive ready did not hold cycle");
  sync_ready_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (state_reg == ebc_pkg::ST_E && tmr.last && cfg_reg.ready_en
     && !cfg_reg.ready_async && ready_ok)
    |=> state_reg != ebc_pkg::ST_WAIT ##0 done_out)
    else $error("sync ready did not end access");
  rdata_capture_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    (done_out && !write_reg) |-> rdata_out == $past(data_in)
                                 && $rose(rd_n_out))
    else $error("read data not captured at strobe rise");
  hold_finish_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    in_cycle |=> state_reg != ebc_pkg::ST_REL)
    else $error("bus released during a cycle");
  release_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    $rose(state_reg == ebc_pkg::ST_RELEASED)
    |-> !ctrl_oe_out && !ale_out && $past(ctrl_oe_out && rd_n_out
        && wr_n_out && cs_n_out))
    else $error("controls not driven inactive before float");
  regain_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    $fell(state_reg == ebc_pkg::ST_RELEASED)
    |-> hold_n_sync && ctrl_oe_out && rd_n_out && !ale_out
        ##1 state_reg == ebc_pkg::ST_IDLE)
    else $error("regain sequence wrong");
  grant_a: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    bus_regain_request_out |-> bus_grant_acknowledge_out && !ctrl_oe_out)
    else $error("regain request outside release");

  read_cov_c: cover property (@(posedge clock_in)
    disable iff (!rst_n_in) done_out && !write_reg);
  wait_cov_c: cover property (@(posedge clock_in)
    disable iff (!rst_n_in)
    state_reg == ebc_pkg::ST_WAIT ##1 state_reg == ebc_pkg::ST_WAIT);
  hold_cov_c: cover property (@(posedge clock_in)
    disable iff (!rst_n_in)
    bus_regain_request_out ##1 !bus_grant_acknowledge_out);
endmodule // ebc_bus_cycle

//--- tb/ebc_partner.sv
module ebc_partner (
  input  wire logic        clock_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [5:0]  delay_in,
  input  wire logic        ready_pol_in,
  output logic             ready_out,
  output logic [15:0]      data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt;
  logic       active;
  initial begin
    cnt = 6'h00;
    active = 1'b0;
    ready_out = 1'b0;
    data_out = 16'h0000;
  end
  always @(negedge clock_in) begin
    if (!rd_n_in || !wr_n_in) begin
      cnt = cnt + 6'h01;
      active = (cnt >= delay_in);
    end else begin
      cnt = 6'h00;
      active = 1'b0;
    end
    ready_out <= active ? ready_pol_in : ~ready_pol_in;
    // Released data bus shows garbage, not the last word
    data_out <= !rd_n_in ? (addr_in[15:0] ^ 16'ha5c3) : ~data_out;
  end
endmodule // ebc_partner

//--- tb/ebc_bus_cycle_tb_top.sv
module ebc_bus_cycle_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [15:0] cfg;
    logic        wr;
    logic [2:0]  win;
    logic [5:0]  dly;
    int          ab;
    int          cs;
    int          cmd;
  } ebc_row_t;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  ebc_pkg::ebc_cfg_t cfg = '0;
  logic              valid = 1'b0;
  logic              wr = 1'b0;
  logic              upper = 1'b0;
  logic [23:0]       addr = 24'h000000;
  logic [2:0]        win = 3'h0;
  logic [15:0]       wdata = 16'h0000;
  logic              hold_n = 1'b1;
  logic [5:0]        dly = 6'h01;
  logic              pol = 1'b1;
  logic              rdy_q, done, ube_n, ale, cs_n, rd_n, wr_n, ctrl_oe;
  logic              doe, ready, grant, regain;
  logic [15:0]       rdata, din, dout;
  logic [23:0]       a_out;
  logic [4:0]        prev;
  int                miscompares = 0;
  int                comparisons = 0;
  int                ab, cs, cmd, n;
  ebc_row_t rows [8] = '{
    '{16'h0000, 1'b0, 3'h0, 6'h01, 1, 2, 1},
    '{16'h9c98, 1'b1, 3'h0, 6'h01, 2, 14, 5},
    '{16'h63e8, 1'b0, 3'h5, 6'h01, 4, 37, 32},
    '{16'h6000, 1'b0, 3'h5, 6'h01, 1, 2, 1},
    '{16'hc800, 1'b1, 3'h2, 6'h01, 4, 6, 1},
    '{16'h0006, 1'b0, 3'h2, 6'h03, 1, 4, 3},
    '{16'h0064, 1'b0, 3'h2, 6'h01, 1, 5, 4},
    '{16'h0006, 1'b1, 3'h2, 6'h02, 1, 3, 2}
  };

  always #5 clk = ~clk;

  ebc_bus_cycle dut (
    .clock_in(clk), .rst_n_in(rst_n), .chip_select_timing_config_in(cfg),
    .req_valid_in(valid), .req_write_in(wr), .req_upper_in(upper),
    .req_addr_in(addr), .req_window_in(win), .req_wdata_in(wdata),
    .req_ready_out(rdy_q), .done_out(done), .rdata_out(rdata),
    .addr_out(a_out), .upper_byte_enable_n_out(ube_n), .ale_out(ale),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .ctrl_oe_out(ctrl_oe), .data_in(din), .data_out(dout),
    .data_oe_out(doe), .ready_in(ready), .hold_n_in(hold_n),
    .bus_grant_acknowledge_out(grant), .bus_regain_request_out(regain)
  );

  ebc_partner mem (
    .clock_in(clk), .rd_n_in(rd_n), .wr_n_in(wr_n), .addr_in(a_out),
    .delay_in(dly), .ready_pol_in(pol), .ready_out(ready), .data_out(din)
  );

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic run_op(input ebc_row_t r, input logic [23:0] a);
    logic got_done;
    int   k;
    @(negedge clk);
    cfg = r.cfg;
    wr = r.wr;
    upper = r.wr;
    win = r.win;
    addr = a;
    wdata = a[15:0] ^ 16'h0f0f;
    dly = r.dly;
    pol = r.cfg[1];
    valid = 1'b1;
    k = 0;
    while (rdy_q !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    valid = 1'b0;
    ab = 0;
    cs = 0;
    cmd = 0;
    got_done = 1'b0;
    k = 0;
    do begin
      if (ale === 1'b1) ab++;
      if (cs_n === 1'b0) cs++;
      if (rd_n === 1'b0 || wr_n === 1'b0) cmd++;
      if (wr_n === 1'b0) check("write_data", {doe, dout}, {1'b1, wdata});
      if (cs_n === 1'b0)
        check("addr_ube", {ube_n, a_out}, {~upper, a});
      check("grant_in_cycle", grant & ~cs_n, 0);
      if (done === 1'b1) begin
        got_done = 1'b1;
        if (!r.wr) check("read_data", rdata, a[15:0] ^ 16'ha5c3);
      end
      @(negedge clk);
      k++;
    end while ((cs_n === 1'b0 || !got_done) && k < 300);
  endtask

  task automatic wait_grant(input logic lvl);
    n = 0;
    while (grant !== lvl && n < 20) begin
      prev = {ctrl_oe, cs_n, rd_n, wr_n, ale};
      @(negedge clk);
      n++;
    end
    check("grant_level", grant, lvl);
  endtask

  // Whole sequence needs well under 1000 cycles
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (16) @(negedge clk);
    check("reset_pins", {ale, cs_n, rd_n, wr_n, ctrl_oe, doe, grant, done},
          8'h78);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      run_op(rows[i], 24'h012340 + 24'(i));
      check("setup_len", ab, rows[i].ab);
      check("cycle_len", cs, rows[i].cs);
      check("access_len", cmd, rows[i].cmd);
      $display("Row %0d finished", i);
    end
    // Asynchronous ready costs a synchroniser delay
    run_op(ebc_row_t'{16'h0007, 1'b0, 3'h2, 6'h01, 1, 2, 2}, 24'h00abcd);
    check("async_wait", (cmd >= 2) && (cmd <= 6), 1);
    $display("Async ready test finished");
    // Hold arrives in mid-cycle
    fork
      run_op(rows[2], 24'h004321);
      begin
        repeat (4) @(negedge clk);
        hold_n = 1'b0;
      end
    join
    check("held_cycle_len", cs, rows[2].cs);
    wait_grant(1'b1);
    check("release_order", prev, 5'h1e);
    check("released_pins", {ctrl_oe, ale, rdy_q}, 3'h0);
    cfg = '0;
    valid = 1'b1;
    repeat (5) @(negedge clk);
    check("regain_req", {grant, regain}, 2'h3);
    hold_n = 1'b1;
    wait_grant(1'b0);
    check("floated_before", prev[4], 1'b0);
    check("regain_pins", {ctrl_oe, cs_n, rd_n, wr_n, ale}, 5'h1e);
    run_op(rows[0], 24'h000100);
    check("after_regain", cs, 2);
    $display("Hold with regain request finished");
    // Master leaves without being asked
    @(negedge clk);
    hold_n = 1'b0;
    wait_grant(1'b1);
    check("no_regain_req", regain, 1'b0);
    hold_n = 1'b1;
    wait_grant(1'b0);
    repeat (2) @(negedge clk);
    check("ready_again", rdy_q, 1'b1);
    $display("Unrequested hold end finished");
    // Reset in mid-cycle
    fork
      run_op(rows[2], 24'h000200);
      begin
        repeat (6) @(negedge clk);
        rst_n = 1'b0;
      end
    join
    check("mid_reset", {ale, cs_n, rd_n, wr_n, ctrl_oe, doe, grant}, 7'h3c);
    rst_n = 1'b1;
    run_op(rows[0], 24'h000300);
    check("after_reset", cs, 2);
    $display("Mid-run reset finished");
    give_verdict();
  end
endmodule // ebc_bus_cycle_tb_top
